//--- inc/arsl_pkg.sv
// Constants and types shared by the analog reference block.
package arsl_pkg;
  localparam logic [15:0] ADDR_OUT1_LEVEL = 16'h043C;
  localparam logic [15:0] ADDR_OUT2_LEVEL = 16'h043D;
  localparam logic [15:0] ADDR_MASK       = 16'h043E;
  localparam logic [15:0] ADDR_LOSS1      = 16'h043F;
  localparam logic [15:0] ADDR_LOSS2      = 16'h0440;
  localparam logic [15:0] ADDR_MON1       = 16'h0441;
  localparam logic [15:0] ADDR_MON2       = 16'h0442;
  localparam logic [15:0] ADDR_MON3       = 16'h0443;
  localparam logic [15:0] RESET_VALUE     = 16'h0000;
  localparam logic [15:0] LEVEL_MAX       = 16'h2710;
  localparam logic [15:0] LOSS_RESP_MAX   = 16'h0003;
  localparam int          PCT_FULL        = 32'h0000_2710;
  localparam int          VOLT_MULT       = 32'h0000_000A;
  localparam int          CURR_MULT       = 32'h0000_0005;
  localparam int          GAIN_UNITY      = 32'h0000_03E8;
  localparam int          SYNC_STAGES     = 32'h0000_0003;
  typedef enum logic [1:0] {
    RANGE_VOLT = 2'h0, RANGE_0_20 = 2'h1, RANGE_4_20 = 2'h2
  } range_t;
  typedef enum logic [1:0] {
    POL_NONE = 2'h0, POL_POS = 2'h1, POL_NEG = 2'h2
  } polarity_t;
  typedef enum logic [1:0] {
    LOSS_DECEL = 2'h0, LOSS_HOLD = 2'h1, LOSS_DECEL_WARN = 2'h2, LOSS_STOP = 2'h3
  } loss_resp_t;
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0, SRC_IN1 = 2'h1, SRC_IN2 = 2'h2, SRC_IN3 = 2'h3
  } source_t;
endpackage

//--- inc/arsl_if.sv
// Interfaces between the reference block and its scaler and loss monitors.
`timescale 1ns/100ps
`default_nettype none
interface scale_if;
  import arsl_pkg::*;
  logic signed [15:0] frac;
  logic [15:0]        gain;
  logic [15:0]        bias;
  logic [15:0]        fmax;
  polarity_t          pol;
  logic               curve_zero;
  logic [15:0]        freq;
  modport ctrl (output frac, gain, bias, fmax, pol, curve_zero, input freq);
  modport calc (input frac, gain, bias, fmax, pol, curve_zero, output freq);
endinterface

interface loss_if;
  import arsl_pkg::*;
  logic       loss;
  logic       active;
  logic       is_420;
  logic       clr;
  loss_resp_t resp;
  logic       warn;
  logic       fault;
  logic       decel;
  logic       hold;
  modport ctrl (output loss, active, is_420, clr, resp, input warn, fault, decel, hold);
  modport mon (input loss, active, is_420, clr, resp, output warn, fault, decel, hold);
endinterface
`default_nettype wire

//--- core/input_scaler.sv
// Gain, bias and maximum-frequency scaling of one input fraction.
`timescale 1ns/100ps
`default_nettype none
module input_scaler (
  scale_if.calc s
);
  import arsl_pkg::*;
  logic signed [47:0] gain_term;
  logic signed [47:0] bias_term;
  logic signed [47:0] fmax_term;
  logic signed [47:0] sum;
  logic signed [47:0] prod;

  always_comb begin
    fmax_term = 48'(signed'({1'b0, s.fmax}));
    if (s.curve_zero) begin
      gain_term = 48'(s.frac) * 48'(signed'({1'b0, s.gain})) / GAIN_UNITY;
    end else begin
      gain_term = 48'(s.frac);
    end
    bias_term = '0;
    if (s.curve_zero && s.pol == POL_POS) begin
      bias_term = 48'(signed'({1'b0, s.bias}));
    end
    if (s.curve_zero && s.pol == POL_NEG) begin
      bias_term = -48'(signed'({1'b0, s.bias}));
    end
    sum = gain_term + bias_term;
    prod = sum * fmax_term / PCT_FULL;
    if (prod < 0) begin
      s.freq = RESET_VALUE;
    end else if (prod > fmax_term) begin
      s.freq = s.fmax;
    end else begin
      s.freq = prod[15:0];
    end
  end
endmodule
`default_nettype wire

//--- core/loss_monitor.sv
// Loss-of-signal response state machine for one current-loop input.
`timescale 1ns/100ps
`default_nettype none
module loss_monitor (
  input wire logic clock,
  input wire logic rst,
  loss_if.mon      l
);
  import arsl_pkg::*;
  typedef enum logic [4:0] {
    ST_OK    = 5'h01,
    ST_DECEL = 5'h02,
    ST_HOLD  = 5'h04,
    ST_WDEC  = 5'h08,
    ST_FAULT = 5'h10
  } lstate_t;
  typedef struct packed {
    lstate_t st;
  } lm_state_t;
  lm_state_t q_reg;
  lm_state_t q_next;
  logic      watch;
  logic      start;

  assign watch = l.active && l.is_420;
  assign start = (q_reg.st == ST_OK) && watch && l.loss;

  always_comb begin
    q_next = q_reg;
    case (q_reg.st)
      ST_OK: begin
        if (start) begin
          case (l.resp)
            LOSS_DECEL: q_next.st = ST_DECEL;
            LOSS_HOLD: q_next.st = ST_HOLD;
            LOSS_DECEL_WARN: q_next.st = ST_WDEC;
            default: q_next.st = ST_FAULT;
          endcase
        end
      end
      ST_DECEL, ST_HOLD, ST_WDEC: begin
        if (!l.loss || !watch) begin
          q_next.st = ST_OK;
        end
      end
      ST_FAULT: begin
        if (!l.loss && l.clr) begin
          q_next.st = ST_OK;
        end
      end
      default: q_next.st = ST_OK;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_reg <= '{st: ST_OK};
    end else begin
      q_reg <= q_next;
    end
  end

  assign l.decel = (q_reg.st == ST_DECEL) || (q_reg.st == ST_WDEC);
  assign l.hold  = (q_reg.st == ST_HOLD);
  assign l.warn  = (q_reg.st == ST_HOLD) || (q_reg.st == ST_WDEC);
  assign l.fault = (q_reg.st == ST_FAULT);

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  property p_resp0;
    start && l.resp == LOSS_DECEL |=> l.decel && !l.warn && !l.fault;
  endproperty
  a_resp0: assert property (p_resp0) else $error("Response 0 wrong.");
  property p_resume;
    l.decel && !l.warn && !l.loss |=> !l.decel;
  endproperty
  a_resume: assert property (p_resume) else $error("No resume after return.");
  property p_resp1;
    start && l.resp == LOSS_HOLD |=> l.hold && l.warn && !l.decel;
  endproperty
  a_resp1: assert property (p_resp1) else $error("Response 1 wrong.");
  property p_resp2;
    start && l.resp == LOSS_DECEL_WARN |=> l.decel && l.warn;
  endproperty
  a_resp2: assert property (p_resp2) else $error("Response 2 wrong.");
  property p_resp3;
    start && l.resp == LOSS_STOP |=> l.fault && !l.warn;
  endproperty
  a_resp3: assert property (p_resp3) else $error("Response 3 wrong.");
  property p_fault_hold;
    l.fault && !(!l.loss && l.clr) |=> l.fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("Fault cleared early.");
  property p_warn_keep;
    l.warn && l.loss && watch |=> l.warn;
  endproperty
  a_warn_keep: assert property (p_warn_keep) else $error("Warning dropped early.");
  property p_ignore;
    (q_reg.st == ST_OK) && !watch |=> !l.warn && !l.fault && !l.decel;
  endproperty
  a_ignore: assert property (p_ignore) else $error("Loss acted while unused.");
endmodule
`default_nettype wire

//--- core/analog_reference_scaling_loss_handler.sv
// Analog input scaling, loss handling, monitors and fixed output levels.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Fixed-mode output drives its constant level; keypad or port writes change it.
// - Port-written constant level spans 0 to 10000 for 0.00 to 100.00 percent.
// - Mask bit per analog output shows external control; bit 1 is output two.
// - Response 0 decelerates to zero silently and resumes on signal return.
// - Response 1 holds last frequency, warns, then tracks the returned input.
// - Response 2 decelerates to zero, warns, restarts when input returns.
// - Response 3 stops immediately, raises loss fault, no automatic restart.
// - Loss fault persists until signal restored and a reset command arrives.
// - Loss response of inputs one and two applies only in 4-20mA range.
// - Warning for responses 1 and 2 stays active until signal restored.
// - Loss warnings and faults evaluated only while input is active reference.
// - Read-only signed monitor per input reports -100 to 100 percent.
// - Polarity 1: reference is fraction times gain plus bias, times max frequency.
// - Polarity 2: reference is fraction times gain minus bias, times max frequency.
// - Fraction is volts over 10, or milliamps over 20 for current inputs.
// - Gain and bias apply only when calculated-curve selection is zero.
// - Third input uses positive gain at polarity 1, negative gain at polarity 2.
module analog_reference_scaling_loss_handler (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [15:0]         reg_addr,
  input  wire logic [15:0]         reg_wdata,
  output logic [15:0]              reg_rdata,
  output logic                     reg_rvalid,
  input  wire logic                keypad_wr,
  input  wire logic                keypad_out_sel,
  input  wire logic [15:0]         keypad_level,
  input  wire logic [1:0]          out_fixed_mode,
  output logic [15:0]              output1_level,
  output logic [15:0]              output2_level,
  output logic [1:0]               ao_ext_owned,
  input  wire logic [2:0][15:0]    ain_value,
  input  wire arsl_pkg::range_t    input1_range_select,
  input  wire arsl_pkg::range_t    input2_range_select,
  input  wire arsl_pkg::range_t    input3_range_select,
  input  wire logic [15:0]         input1_gain,
  input  wire logic [15:0]         input2_gain,
  input  wire logic [15:0]         input3_positive_gain,
  input  wire logic [15:0]         input3_negative_gain,
  input  wire logic [15:0]         input1_bias,
  input  wire logic [15:0]         input2_bias,
  input  wire logic [15:0]         input3_bias,
  input  wire arsl_pkg::polarity_t input1_bias_polarity,
  input  wire arsl_pkg::polarity_t input2_bias_polarity,
  input  wire arsl_pkg::polarity_t input3_bias_polarity,
  input  wire logic [15:0]         calculated_curve_selection,
  input  wire logic [15:0]         max_output_frequency,
  input  wire arsl_pkg::source_t   ref_source_select,
  input  wire logic [1:0]          loss_pin,
  input  wire logic                reset_command,
  output logic [15:0]              frequency_reference,
  output logic                     decel_to_zero,
  output logic                     hold_last_frequency,
  output logic                     stop_immediately,
  output logic                     signal_loss_warning,
  output logic                     analog_loss_fault
);
  import arsl_pkg::*;
  typedef struct packed {
    logic [15:0]                  mask;
    logic [1:0][15:0]             loss_resp;
    logic [1:0][15:0]             level;
    logic [1:0][15:0]             ao;
    logic [2:0][15:0]             mon;
    logic [1:0][SYNC_STAGES-1:0]  sync;
    logic [1:0]                   lost;
    logic [15:0]                  rdata;
    logic                         rvalid;
    logic [15:0]                  freq;
  } top_state_t;
  top_state_t      q_reg;
  top_state_t      q_next;
  logic [2:0][1:0] rng;
  logic [15:0]     frac [3];
  logic [1:0]      warn_v;
  logic [1:0]      fault_v;
  logic [1:0]      decel_v;
  logic [1:0]      hold_v;
  scale_if         sif ();

  assign rng = {input3_range_select, input2_range_select, input1_range_select};

  for (genvar i = 0; i < 3; i++) begin : g_frac
    logic signed [31:0] raw;
    assign raw = 32'(signed'(ain_value[i])) * ((rng[i] == RANGE_VOLT) ? VOLT_MULT : CURR_MULT);
    assign frac[i] = (raw > PCT_FULL) ? 16'(PCT_FULL) :
                     (raw < -PCT_FULL) ? 16'(-PCT_FULL) : raw[15:0];
  end

  for (genvar i = 0; i < 2; i++) begin : g_loss
    loss_if lif ();
    assign lif.loss   = q_reg.lost[i];
    assign lif.active = (ref_source_select == ((i == 0) ? SRC_IN1 : SRC_IN2));
    assign lif.is_420 = (rng[i] == RANGE_4_20);
    assign lif.resp   = loss_resp_t'(q_reg.loss_resp[i][1:0]);
    assign lif.clr    = reset_command;
    assign warn_v[i]  = lif.warn;
    assign fault_v[i] = lif.fault;
    assign decel_v[i] = lif.decel;
    assign hold_v[i]  = lif.hold;
    loss_monitor loss_monitor_inst (
      .clock (clock),
      .rst   (rst),
      .l     (lif.mon)
    );
  end

  always_comb begin
    sif.frac = RESET_VALUE;
    sif.gain = RESET_VALUE;
    sif.bias = RESET_VALUE;
    sif.pol  = POL_NONE;
    case (ref_source_select)
      SRC_IN1: begin
        sif.frac = frac[0];
        sif.gain = input1_gain;
        sif.bias = input1_bias;
        sif.pol  = input1_bias_polarity;
      end
      SRC_IN2: begin
        sif.frac = frac[1];
        sif.gain = input2_gain;
        sif.bias = input2_bias;
        sif.pol  = input2_bias_polarity;
      end
      SRC_IN3: begin
        sif.frac = frac[2];
        sif.gain = (input3_bias_polarity == POL_NEG) ? input3_negative_gain
                                                     : input3_positive_gain;
        sif.bias = input3_bias;
        sif.pol  = input3_bias_polarity;
      end
      default: sif.frac = RESET_VALUE;
    endcase
  end
  assign sif.fmax = max_output_frequency;
  assign sif.curve_zero = (calculated_curve_selection == RESET_VALUE);

  input_scaler input_scaler_inst (
    .s (sif.calc)
  );

  always_comb begin
    q_next = q_reg;
    q_next.rvalid = 1'b0;
    // Only the second and third stages decide; the first stage just absorbs metastability.
    for (int i = 0; i < 2; i++) begin
      q_next.sync[i] = {q_reg.sync[i][SYNC_STAGES-2:0], loss_pin[i]};
      if (q_reg.sync[i][SYNC_STAGES-2] == q_reg.sync[i][SYNC_STAGES-1]) begin
        q_next.lost[i] = q_reg.sync[i][SYNC_STAGES-1];
      end
    end
    for (int i = 0; i < 3; i++) begin
      q_next.mon[i] = frac[i];
    end
    for (int i = 0; i < 2; i++) begin
      q_next.ao[i] = out_fixed_mode[i] ? q_reg.level[i] : RESET_VALUE;
    end
    // A port write in the same cycle takes the place of a keypad change.
    if (reg_wr) begin
      case (reg_addr)
        ADDR_OUT1_LEVEL: if (reg_wdata <= LEVEL_MAX) q_next.level[0] = reg_wdata;
        ADDR_OUT2_LEVEL: if (reg_wdata <= LEVEL_MAX) q_next.level[1] = reg_wdata;
        ADDR_MASK: q_next.mask = reg_wdata;
        ADDR_LOSS1: if (reg_wdata <= LOSS_RESP_MAX) q_next.loss_resp[0] = reg_wdata;
        ADDR_LOSS2: if (reg_wdata <= LOSS_RESP_MAX) q_next.loss_resp[1] = reg_wdata;
        default: q_next.mask = q_reg.mask;
      endcase
    end else if (keypad_wr && keypad_level <= LEVEL_MAX) begin
      q_next.level[keypad_out_sel] = keypad_level;
    end
    if (reg_rd) begin
      q_next.rvalid = 1'b1;
      case (reg_addr)
        ADDR_OUT1_LEVEL: q_next.rdata = q_reg.level[0];
        ADDR_OUT2_LEVEL: q_next.rdata = q_reg.level[1];
        ADDR_MASK: q_next.rdata = q_reg.mask;
        ADDR_LOSS1: q_next.rdata = q_reg.loss_resp[0];
        ADDR_LOSS2: q_next.rdata = q_reg.loss_resp[1];
        ADDR_MON1: q_next.rdata = q_reg.mon[0];
        ADDR_MON2: q_next.rdata = q_reg.mon[1];
        ADDR_MON3: q_next.rdata = q_reg.mon[2];
        default: q_next.rdata = RESET_VALUE;
      endcase
    end
    if (ref_source_select == SRC_NONE || (|fault_v) || (|decel_v)) begin
      q_next.freq = RESET_VALUE;
    end else if (!(|hold_v)) begin
      q_next.freq = sif.freq;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign reg_rdata           = q_reg.rdata;
  assign reg_rvalid          = q_reg.rvalid;
  assign output1_level       = q_reg.ao[0];
  assign output2_level       = q_reg.ao[1];
  assign ao_ext_owned        = q_reg.mask[1:0];
  assign frequency_reference = q_reg.freq;
  assign decel_to_zero       = |decel_v;
  assign hold_last_frequency = |hold_v;
  assign stop_immediately    = |fault_v;
  assign signal_loss_warning = |warn_v;
  assign analog_loss_fault   = |fault_v;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  property p_fixed_out;
    out_fixed_mode[0] |=> output1_level == $past(q_reg.level[0]);
  endproperty
  a_fixed_out: assert property (p_fixed_out) else $error("Fixed level not driven.");
  property p_level_range;
    reg_wr && reg_addr == ADDR_OUT2_LEVEL && reg_wdata > LEVEL_MAX |=> $stable(q_reg.level[1]);
  endproperty
  a_level_range: assert property (p_level_range) else $error("Level over full scale.");
  property p_mask;
    reg_wr && reg_addr == ADDR_MASK |=> ao_ext_owned == $past(reg_wdata[1:0]);
  endproperty
  a_mask: assert property (p_mask) else $error("Mask not reported.");
  property p_mon_read;
    reg_rd && reg_addr == ADDR_MON1 |=> reg_rvalid && reg_rdata == $past(q_reg.mon[0]);
  endproperty
  a_mon_read: assert property (p_mon_read) else $error("Monitor readback wrong.");
  property p_mon_range;
    $signed(q_reg.mon[2]) <= PCT_FULL && $signed(q_reg.mon[2]) >= -PCT_FULL;
  endproperty
  a_mon_range: assert property (p_mon_range) else $error("Monitor out of range.");
  property p_hold;
    hold_last_frequency && !decel_to_zero && !stop_immediately
      && ref_source_select != SRC_NONE |=> $stable(frequency_reference);
  endproperty
  a_hold: assert property (p_hold) else $error("Held frequency moved.");
  property p_stop;
    stop_immediately |=> frequency_reference == RESET_VALUE;
  endproperty
  a_stop: assert property (p_stop) else $error("Fault did not stop.");
  property p_clamp;
    ##1 frequency_reference <= $past(max_output_frequency);
  endproperty
  a_clamp: assert property (p_clamp) else $error("Reference above maximum.");
endmodule
`default_nettype wire

//--- sim/analog_source_model.sv
// Behavioural model of the analog signal sources and the supervising controller.
`timescale 1ns/100ps
`default_nettype none
module analog_source_model (
  input  wire logic             clock,
  input  wire logic [2:0][15:0] signal_level,
  input  wire logic [1:0]       drop,
  input  wire logic             clear_req,
  output logic [2:0][15:0]      ain_value,
  output logic [1:0]            loss_pin,
  output logic                  reset_command
);
  // A loop break is flagged at once; the sampled value only falls six cycles later.
  logic [1:0][5:0] drop_line;

  always_ff @(posedge clock) begin
    drop_line <= {drop_line[1][4:0], drop[1], drop_line[0][4:0], drop[0]};
    for (int i = 0; i < 3; i++) begin
      if (i < 2 && drop_line[i][5]) begin
        ain_value[i] <= 16'h0000;
      end else if ($signed(signal_level[i]) > $signed(16'h07D0)) begin
        ain_value[i] <= 16'h07D0;
      end else begin
        ain_value[i] <= signal_level[i];
      end
    end
    loss_pin <= drop;
    reset_command <= clear_req;
  end
endmodule
`default_nettype wire

//--- sim/analog_reference_scaling_loss_handler_test.sv
// Self-checking bench for the analog reference scaling and loss handler.
`timescale 1ns/100ps
`default_nettype none
module analog_reference_scaling_loss_handler_test;
  import arsl_pkg::*;
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic             keypad_wr = 1'b0;
  logic             keypad_out_sel = 1'b0;
  logic             clear_req = 1'b0;
  logic [15:0]      reg_addr = 16'h0000;
  logic [15:0]      reg_wdata = 16'h0000;
  logic [15:0]      keypad_level = 16'h0000;
  logic [1:0]       out_fixed_mode = 2'h0;
  logic [1:0]       drop = 2'h0;
  logic [2:0][15:0] signal_level = '0;
  logic [15:0]      input1_gain = 16'h03E8;
  logic [15:0]      input2_gain = 16'h03E8;
  logic [15:0]      input3_positive_gain = 16'h03E8;
  logic [15:0]      input3_negative_gain = 16'h03E8;
  logic [15:0]      input1_bias = 16'h0000;
  logic [15:0]      input2_bias = 16'h0000;
  logic [15:0]      input3_bias = 16'h0000;
  logic [15:0]      calculated_curve_selection = 16'h0000;
  logic [15:0]      max_output_frequency = 16'h1770;
  range_t           input1_range_select = RANGE_VOLT;
  range_t           input2_range_select = RANGE_VOLT;
  range_t           input3_range_select = RANGE_VOLT;
  polarity_t        input1_bias_polarity = POL_NONE;
  polarity_t        input2_bias_polarity = POL_NONE;
  polarity_t        input3_bias_polarity = POL_NONE;
  source_t          ref_source_select = SRC_NONE;
  logic [15:0]      reg_rdata, output1_level, output2_level, frequency_reference, rd_data;
  logic [2:0][15:0] ain_value;
  logic [1:0]       loss_pin, ao_ext_owned;
  logic             reg_rvalid, reset_command, decel_to_zero, hold_last_frequency;
  logic             stop_immediately, signal_loss_warning, analog_loss_fault;
  int               bad_count = 0;
  int               checks_done = 0;

  always #2 clock = ~clock;

  analog_source_model analog_source_model_inst (
    .clock, .signal_level, .drop, .clear_req, .ain_value, .loss_pin, .reset_command
  );

  analog_reference_scaling_loss_handler analog_reference_scaling_loss_handler_inst (
    .clock, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .keypad_wr, .keypad_out_sel, .keypad_level, .out_fixed_mode, .output1_level,
    .output2_level, .ao_ext_owned, .ain_value, .input1_range_select, .input2_range_select,
    .input3_range_select, .input1_gain, .input2_gain, .input3_positive_gain,
    .input3_negative_gain, .input1_bias, .input2_bias, .input3_bias, .input1_bias_polarity,
    .input2_bias_polarity, .input3_bias_polarity, .calculated_curve_selection,
    .max_output_frequency, .ref_source_select, .loss_pin, .reset_command, .frequency_reference,
    .decel_to_zero, .hold_last_frequency, .stop_immediately, .signal_loss_warning,
    .analog_loss_fault
  );

  task automatic close_out();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // The answer stands for the single cycle after the read edge.
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check("reg_rvalid", {15'h0000, reg_rvalid}, 16'h0001); // read answer
    d = reg_rdata;
  endtask

  task automatic lose(input logic [1:0] d);
    @(posedge clock);
    drop <= d;
    tick(10);
  endtask

  task automatic pulse_clear();
    @(posedge clock);
    clear_req <= 1'b1;
    @(posedge clock);
    clear_req <= 1'b0;
    tick(4);
  endtask

  // All three inputs get the same setting; src picks which one steers the reference.
  task automatic freq_case(input source_t src, input range_t rng, input logic [15:0] val,
      input logic [15:0] g, input logic [15:0] gn, input logic [15:0] b, input polarity_t p,
      input logic [15:0] c, input logic [15:0] exp);
    @(posedge clock);
    ref_source_select <= src;
    input1_range_select <= rng;
    input2_range_select <= rng;
    input3_range_select <= rng;
    input1_gain <= g;
    input2_gain <= g;
    input3_positive_gain <= g;
    input3_negative_gain <= gn;
    input1_bias <= b;
    input2_bias <= b;
    input3_bias <= b;
    input1_bias_polarity <= p;
    input2_bias_polarity <= p;
    input3_bias_polarity <= p;
    calculated_curve_selection <= c;
    signal_level <= {val, val, val};
    tick(4);
    check("frequency_reference", frequency_reference, exp);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int a = 16'h043C; a <= 16'h0444; a++) begin
      rd(16'(a), rd_data);
      check("reset_read", rd_data, 16'h0000); // zero after reset
    end
    wr(ADDR_MASK, 16'h0002);
    tick(2);
    check("ao_ext_owned", {14'h0000, ao_ext_owned}, 16'h0002); // second output owned
    rd(ADDR_MASK, rd_data);
    check("mask", rd_data, 16'h0002); // mask readback
    wr(ADDR_OUT1_LEVEL, 16'h2711);
    rd(ADDR_OUT1_LEVEL, rd_data);
    check("level_over", rd_data, 16'h0000); // above full scale
    wr(ADDR_OUT1_LEVEL, 16'h2710);
    @(posedge clock);
    out_fixed_mode <= 2'b01;
    tick(3);
    check("output1_level", output1_level, 16'h2710); // fixed level
    @(posedge clock);
    keypad_wr <= 1'b1;
    keypad_out_sel <= 1'b1;
    keypad_level <= 16'h09C4;
    out_fixed_mode <= 2'b11;
    @(posedge clock);
    keypad_wr <= 1'b0;
    tick(3);
    check("output2_level", output2_level, 16'h09C4); // keypad change
    @(posedge clock);
    out_fixed_mode <= 2'b01;
    tick(3);
    check("output2_level", output2_level, 16'h0000); // not fixed mode
    wr(ADDR_OUT2_LEVEL, 16'h2711);
    rd(ADDR_OUT2_LEVEL, rd_data);
    check("level2_over", rd_data, 16'h09C4); // keypad level kept
    wr(ADDR_LOSS1, 16'h0004);
    rd(ADDR_LOSS1, rd_data);
    check("loss_over", rd_data, 16'h0000); // invalid response code
    freq_case(SRC_IN1, RANGE_VOLT, 16'h01F4, 16'h03E8, 16'h03E8, 16'h03E8, POL_POS, 16'h0000,
      16'h0E10); // plus bias
    freq_case(SRC_IN2, RANGE_VOLT, 16'h01F4, 16'h03E8, 16'h03E8, 16'h03E8, POL_NEG, 16'h0000,
      16'h0960); // minus bias
    freq_case(SRC_IN1, RANGE_VOLT, 16'h01F4, 16'h03E8, 16'h03E8, 16'h03E8, POL_POS, 16'h0001,
      16'h0BB8); // curve selection nonzero
    freq_case(SRC_IN1, RANGE_VOLT, 16'h01F4, 16'h03E8, 16'h03E8, 16'h1F40, POL_NEG, 16'h0000,
      16'h0000); // floor at zero
    freq_case(SRC_IN2, RANGE_VOLT, 16'h03E8, 16'h03E8, 16'h03E8, 16'h1388, POL_POS, 16'h0000,
      16'h1770); // ceiling at maximum
    freq_case(SRC_IN3, RANGE_VOLT, 16'h01F4, 16'h01F4, 16'h07D0, 16'h03E8, POL_POS, 16'h0000,
      16'h0834); // positive gain
    freq_case(SRC_IN3, RANGE_VOLT, 16'h01F4, 16'h01F4, 16'h07D0, 16'h03E8, POL_NEG, 16'h0000,
      16'h1518); // negative gain
    freq_case(SRC_IN1, RANGE_0_20, 16'h04B0, 16'h03E8, 16'h03E8, 16'h0000, POL_NONE, 16'h0000,
      16'h0E10); // current over twenty
    rd(ADDR_MON1, rd_data);
    check("monitor1", rd_data, 16'h1770); // current percent
    freq_case(SRC_IN1, RANGE_VOLT, 16'hFED4, 16'h03E8, 16'h03E8, 16'h0000, POL_NONE, 16'h0000,
      16'h0000); // negative input
    wr(ADDR_MON1, 16'h1234);
    rd(ADDR_MON1, rd_data);
    check("monitor1", rd_data, 16'hF448); // signed and read only
    rd(ADDR_MON3, rd_data);
    check("monitor3", rd_data, 16'hF448); // third input
    for (int r = 0; r < 4; r++) begin
      freq_case(SRC_IN1, RANGE_4_20, 16'h04B0, 16'h03E8, 16'h03E8, 16'h0000, POL_NONE, 16'h0000,
        16'h0E10); // loop current
      wr(ADDR_LOSS1, 16'(r));
      lose(2'b01);
      check("decel_to_zero", decel_to_zero, r == 0 || r == 2); // slow down
      check("hold_last_frequency", hold_last_frequency, r == 1); // keep frequency
      check("stop_immediately", stop_immediately, r == 3); // immediate stop
      check("signal_loss_warning", signal_loss_warning, r == 1 || r == 2); // warn
      check("analog_loss_fault", analog_loss_fault, r == 3); // fault only at three
      check("frequency_reference", frequency_reference, (r == 1) ? 16'h0E10 : 16'h0000);
      pulse_clear();
      check("analog_loss_fault", analog_loss_fault, r == 3); // signal still lost
      lose(2'b00);
      check("signal_loss_warning", signal_loss_warning, 1'b0); // signal back
      check("analog_loss_fault", analog_loss_fault, r == 3); // no self restart
      check("frequency_reference", frequency_reference, (r == 3) ? 16'h0000 : 16'h0E10);
      pulse_clear();
      check("analog_loss_fault", analog_loss_fault, 1'b0); // reset clears fault
    end
    freq_case(SRC_IN1, RANGE_0_20, 16'h04B0, 16'h03E8, 16'h03E8, 16'h0000, POL_NONE, 16'h0000,
      16'h0E10); // plain current range
    wr(ADDR_LOSS1, 16'h0002);
    lose(2'b01);
    check("signal_loss_warning", signal_loss_warning, 1'b0); // range not loop
    check("decel_to_zero", decel_to_zero, 1'b0); // no slow down
    lose(2'b00);
    freq_case(SRC_IN2, RANGE_4_20, 16'h04B0, 16'h03E8, 16'h03E8, 16'h0000, POL_NONE, 16'h0000,
      16'h0E10); // second input steers
    lose(2'b01);
    check("signal_loss_warning", signal_loss_warning, 1'b0); // input not in use
    check("frequency_reference", frequency_reference, 16'h0E10); // reference unchanged
    lose(2'b00);
    wr(ADDR_LOSS2, 16'h0003);
    lose(2'b10);
    check("analog_loss_fault", analog_loss_fault, 1'b1); // second input fault
    check("frequency_reference", frequency_reference, 16'h0000); // stopped
    lose(2'b00);
    pulse_clear();
    check("analog_loss_fault", analog_loss_fault, 1'b0); // cleared after return
    close_out();
  end
endmodule
`default_nettype wire
